// >>> inc/rcsr_pkg.sv
// ----------------------------------------------------------------------
// shared constants and types for the regulator config/status bank
// ----------------------------------------------------------------------
package rcsr_pkg;

  // register pointers on the two-wire bus
  localparam logic [7:0] ADDR_GAIN56 = 8'h11;   // phase 5/6 balance gain
  localparam logic [7:0] ADDR_GAIN78 = 8'h12;   // phase 7/8 balance gain
  localparam logic [7:0] ADDR_LATCHED = 8'h14;  // latched voltage code
  localparam logic [7:0] ADDR_CURRENT = 8'h15;  // output current reading
  localparam logic [7:0] ADDR_VHIGH = 8'h16;    // voltage reading, upper 8
  localparam logic [7:0] ADDR_VLOW = 8'h17;     // voltage reading, lower 2
  localparam logic [7:0] ADDR_STATUS = 8'h18;   // protection status
  localparam logic [7:0] ADDR_OCFG = 8'h19;     // overcurrent config

  // values after reset, and the value unmapped reads return
  localparam logic [7:0] GAIN_RST = 8'h44;
  localparam logic [7:0] LATCHED_RST = 8'hab;   // 1.1 v target
  localparam logic [7:0] OCFG_RST = 8'h8a;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // field positions
  localparam int ODD_GAIN_LSB = 4;              // odd phase in [6:4]
  localparam int EVEN_GAIN_LSB = 0;             // even phase in [2:0]
  localparam int OC_LSB = 4;                    // total threshold [7:4]
  localparam int WARN_LSB = 1;                  // warning level [3:1]
  localparam int HYS_BIT = 0;                   // warning hysteresis
  localparam logic [3:0] OC_DEFAULT_CODE = 4'h8;  // 130 percent

  // ratio decode, all in tenths of a percent
  localparam logic [10:0] GAIN_BASE = 11'h1f4;  // 50.0
  localparam logic [10:0] GAIN_STEP = 11'h07d;  // 12.5
  localparam logic [10:0] OC_BASE = 11'h1f4;    // 50.0
  localparam logic [10:0] OC_STEP = 11'h064;    // 10.0
  localparam logic [10:0] WARN_BASE = 11'h28a;  // 65.0
  localparam logic [10:0] WARN_STEP = 11'h032;  // 5.0
  localparam logic [10:0] HYS_LOW = 11'h064;    // 10.0
  localparam logic [10:0] HYS_HIGH = 11'h0c8;   // 20.0

  // serial framing
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  // serial slave states, gray along the usual path
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_PTR = 4'h2,
    ST_PTR_ACK = 4'h6,
    ST_WDAT = 4'h7,
    ST_WDAT_ACK = 4'h5,
    ST_RDAT = 4'hb,
    ST_RDAT_ACK = 4'ha
  } rcsr_state_t;

  // whole state of the top module
  typedef struct packed {
    rcsr_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic nack;
    logic [7:0] ptr;
    logic scl_q;
    logic sda_q;
    logic sda_oe;
    logic sda_out;
    logic [7:0] gain56;
    logic [7:0] gain78;
    logic [7:0] latched;
    logic [7:0] ocfg;
    logic [7:0] cur_rd;
    logic [9:0] vsample;
    logic [1:0] vlo;
    logic [7:0] status;
    logic [7:0] target_code;
    logic [3:0] oc_code;
    logic [3:0][10:0] gain_tenths;
    logic [10:0] oc_tenths;
    logic [10:0] warn_tenths;
    logic [10:0] hys_tenths;
  } rcsr_regs_t;

endpackage

// >>> design/rcsr_ratio_decode.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// ratio decoder: register codes to tenths of a percent
// ----------------------------------------------------------------------
module rcsr_ratio_decode (
  input wire logic [7:0] gain56,
  input wire logic [7:0] gain78,
  input wire logic [3:0] oc_code,
  input wire logic [2:0] warn_code,
  input wire logic hys_sel,
  output logic [3:0][10:0] gain_tenths,
  output logic [10:0] oc_tenths,
  output logic [10:0] warn_tenths,
  output logic [10:0] hys_tenths
);

  // codes packed phase 8..5, three bits each
  logic [11:0] codes;

  assign codes = {gain78[rcsr_pkg::EVEN_GAIN_LSB +: 3], gain78[rcsr_pkg::ODD_GAIN_LSB +: 3],
                  gain56[rcsr_pkg::EVEN_GAIN_LSB +: 3], gain56[rcsr_pkg::ODD_GAIN_LSB +: 3]};

  // ----------------------------------------------------------------------
  // per-phase balance gain, 50 to 137.5 percent
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < 4; i++)
  begin : g_phase
    assign gain_tenths[i] = rcsr_pkg::GAIN_BASE
                          + rcsr_pkg::GAIN_STEP * {8'h00, codes[i*3 +: 3]};
  end

  // total threshold 50..200, warning 65..100, hysteresis 10 or 20
  assign oc_tenths = rcsr_pkg::OC_BASE + rcsr_pkg::OC_STEP * {7'h00, oc_code};
  assign warn_tenths = rcsr_pkg::WARN_BASE + rcsr_pkg::WARN_STEP * {8'h00, warn_code};
  assign hys_tenths = hys_sel ? rcsr_pkg::HYS_HIGH : rcsr_pkg::HYS_LOW;

endmodule

`default_nettype wire

// >>> design/rcsr_top.sv
// Functional notes
// - 3-bit balance gain per phase 5-8
// - latched voltage code resets to abh
// - override bit selects latched code for converter
// - output current reading, read-only 8 bits
// - voltage reading split 8 high, 2 low
// - select low: reading is converter code
// - select high: reading is sensed voltage
// - status bits 7..4 show live faults
// - bits 3:0 encode faulting phase number
// - total overcurrent ratio 50 to 200 percent
// - warning level ratio 65 to 100 percent
// - bit 0 picks 10 or 20 percent hysteresis
// - programmed threshold used only when enabled
`timescale 1ns/100ps
`default_nettype none

module rcsr_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [6:0] i2c_dev_addr,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [7:0] normal_voltage_code,
  input wire logic latched_code_override_en,
  input wire logic oc_threshold_i2c_en,
  input wire logic voltage_sense_select,
  input wire logic [7:0] adc_current,
  input wire logic [9:0] dac_voltage,
  input wire logic [9:0] sensed_voltage,
  input wire logic total_overcurrent_fault,
  input wire logic [7:0] phase_overcurrent,
  input wire logic overvoltage_fault,
  input wire logic undervoltage_fault,
  output logic [7:0] target_voltage_code,
  output logic [7:0] phase5_6_balance_gain,
  output logic [7:0] phase7_8_balance_gain,
  output logic [3:0][10:0] phase_balance_gain,
  output logic [3:0] oc_threshold_code,
  output logic [10:0] oc_ratio,
  output logic [10:0] overcurrent_warning_level,
  output logic [10:0] overcurrent_warning_hysteresis
);

  // ----------------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------------
  rcsr_pkg::rcsr_regs_t s;       // registered state
  rcsr_pkg::rcsr_regs_t next_s;  // next value

  logic scl_rise;                // clock line low to high
  logic scl_fall;                // clock line high to low
  logic bus_start;               // data falls while clock high
  logic bus_stop;                // data rises while clock high
  logic [9:0] live_v;            // selected voltage source
  logic [3:0] phase_code;        // lowest faulting phase, 1-based
  logic [3:0] applied_oc;        // threshold code in use
  logic [3:0][10:0] dec_gain;    // decoder results
  logic [10:0] dec_oc;
  logic [10:0] dec_warn;
  logic [10:0] dec_hys;

  // edges against last sample; pins are already synchronous
  assign scl_rise = scl_in & ~s.scl_q;
  assign scl_fall = ~scl_in & s.scl_q;
  assign bus_start = scl_in & s.scl_q & s.sda_q & ~sda_in;
  assign bus_stop = scl_in & s.scl_q & ~s.sda_q & sda_in;

  // converter code or sensed voltage
  assign live_v = voltage_sense_select ? sensed_voltage : dac_voltage;

  // bus threshold only when the enable is up, else fixed default
  assign applied_oc = oc_threshold_i2c_en ? s.ocfg[rcsr_pkg::OC_LSB +: 4]
                                          : rcsr_pkg::OC_DEFAULT_CODE;

  // ----------------------------------------------------------------------
  // phase number encode
  // ----------------------------------------------------------------------
  // lowest phase wins when several trip together; reserved codes never made
  function automatic logic [3:0] encode_phase(input logic [7:0] flags);
    logic [3:0] code;
    code = 4'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (flags[i])
      begin
        code = 4'(i + 1);
      end
    end
    return code;
  endfunction

  assign phase_code = encode_phase(phase_overcurrent);

  // ----------------------------------------------------------------------
  // read data for the current pointer
  // ----------------------------------------------------------------------
  function automatic logic [7:0] read_byte(input logic [7:0] a, input rcsr_pkg::rcsr_regs_t r);
    logic [7:0] d;
    d = rcsr_pkg::UNMAPPED_READ;
    unique case (a)
      rcsr_pkg::ADDR_GAIN56: d = r.gain56;
      rcsr_pkg::ADDR_GAIN78: d = r.gain78;
      rcsr_pkg::ADDR_LATCHED: d = r.latched;
      rcsr_pkg::ADDR_CURRENT: d = r.cur_rd;
      rcsr_pkg::ADDR_VHIGH: d = r.vsample[9:2];
      rcsr_pkg::ADDR_VLOW: d = {6'h00, r.vlo};
      rcsr_pkg::ADDR_STATUS: d = r.status;
      rcsr_pkg::ADDR_OCFG: d = r.ocfg;
      default: d = rcsr_pkg::UNMAPPED_READ;  // unmapped reads zero
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------------
  // ratio decode of the configuration fields
  // ----------------------------------------------------------------------
  rcsr_ratio_decode u_decode (
    .gain56(s.gain56),
    .gain78(s.gain78),
    .oc_code(applied_oc),
    .warn_code(s.ocfg[rcsr_pkg::WARN_LSB +: 3]),
    .hys_sel(s.ocfg[rcsr_pkg::HYS_BIT]),
    .gain_tenths(dec_gain),
    .oc_tenths(dec_oc),
    .warn_tenths(dec_warn),
    .hys_tenths(dec_hys)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic load;        // fetch a byte for the host to read
    logic [7:0] rdat;  // fetched byte
    load = 1'b0;
    rdat = 8'h00;
    next_s = s;
    next_s.scl_q = scl_in;
    next_s.sda_q = sda_in;
    // measurement and fault capture, one sample per cycle
    next_s.cur_rd = adc_current;
    next_s.vsample = live_v;
    next_s.status = {total_overcurrent_fault, |phase_overcurrent,
                     overvoltage_fault, undervoltage_fault, phase_code};
    // converter target and decoded settings
    next_s.target_code = latched_code_override_en ? s.latched : normal_voltage_code;
    next_s.oc_code = applied_oc;
    next_s.gain_tenths = dec_gain;
    next_s.oc_tenths = dec_oc;
    next_s.warn_tenths = dec_warn;
    next_s.hys_tenths = dec_hys;

    if (bus_start)
    begin
      // start or repeated start restarts framing
      next_s.st = rcsr_pkg::ST_ADDR;
      next_s.cnt = 4'h0;
      next_s.sda_oe = 1'b0;
    end
    else if (bus_stop)
    begin
      next_s.st = rcsr_pkg::ST_IDLE;
      next_s.sda_oe = 1'b0;
    end
    else
    begin
      unique case (s.st)
        rcsr_pkg::ST_IDLE:
        begin
          next_s.sda_oe = 1'b0;  // line released until addressed
        end
        rcsr_pkg::ST_ADDR, rcsr_pkg::ST_PTR, rcsr_pkg::ST_WDAT:
        begin
          if (scl_rise)
          begin
            next_s.sh = {s.sh[6:0], sda_in};
            next_s.cnt = s.cnt + 4'h1;
          end
          else if (scl_fall && s.cnt == rcsr_pkg::BYTE_BITS)
          begin
            next_s.cnt = 4'h0;
            next_s.sda_oe = 1'b1;  // acknowledge by pulling low
            if (s.st == rcsr_pkg::ST_ADDR)
            begin
              if (s.sh[7:1] == i2c_dev_addr)
              begin
                next_s.rw = s.sh[0];
                next_s.st = rcsr_pkg::ST_ADDR_ACK;
              end
              else
              begin
                // not ours: stay off the line until next start
                next_s.sda_oe = 1'b0;
                next_s.st = rcsr_pkg::ST_IDLE;
              end
            end
            else if (s.st == rcsr_pkg::ST_PTR)
            begin
              next_s.ptr = s.sh;
              next_s.st = rcsr_pkg::ST_PTR_ACK;
            end
            else
            begin
              // only writable registers take data
              unique case (s.ptr)
                rcsr_pkg::ADDR_GAIN56: next_s.gain56 = s.sh;
                rcsr_pkg::ADDR_GAIN78: next_s.gain78 = s.sh;
                rcsr_pkg::ADDR_LATCHED: next_s.latched = s.sh;
                rcsr_pkg::ADDR_OCFG: next_s.ocfg = s.sh;
                default: next_s.ocfg = s.ocfg;  // read-only or unmapped: dropped
              endcase
              next_s.ptr = s.ptr + 8'h01;
              next_s.st = rcsr_pkg::ST_WDAT_ACK;
            end
          end
        end
        rcsr_pkg::ST_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            if (s.rw)
            begin
              load = 1'b1;
            end
            else
            begin
              next_s.sda_oe = 1'b0;
              next_s.st = rcsr_pkg::ST_PTR;
            end
          end
        end
        rcsr_pkg::ST_PTR_ACK, rcsr_pkg::ST_WDAT_ACK:
        begin
          if (scl_fall)
          begin
            next_s.sda_oe = 1'b0;
            next_s.st = rcsr_pkg::ST_WDAT;
          end
        end
        rcsr_pkg::ST_RDAT:
        begin
          if (scl_fall)
          begin
            if (s.cnt == rcsr_pkg::LAST_BIT)
            begin
              // release for the host's acknowledge
              next_s.sda_oe = 1'b0;
              next_s.cnt = 4'h0;
              next_s.st = rcsr_pkg::ST_RDAT_ACK;
            end
            else
            begin
              next_s.sh = {s.sh[6:0], 1'b0};
              next_s.sda_oe = ~s.sh[6];
              next_s.cnt = s.cnt + 4'h1;
            end
          end
        end
        rcsr_pkg::ST_RDAT_ACK:
        begin
          if (scl_rise)
          begin
            next_s.nack = sda_in;
          end
          else if (scl_fall)
          begin
            if (s.nack)
            begin
              next_s.st = rcsr_pkg::ST_IDLE;  // host is done
            end
            else
            begin
              load = 1'b1;
            end
          end
        end
        default:
        begin
          // illegal code: back to a quiet line
          next_s.st = rcsr_pkg::ST_IDLE;
          next_s.sda_oe = 1'b0;
        end
      endcase
    end

    // fetch next read byte and drive its first bit
    if (load)
    begin
      rdat = read_byte(s.ptr, s);
      next_s.sh = rdat;
      next_s.sda_oe = ~rdat[7];
      next_s.cnt = 4'h0;
      next_s.ptr = s.ptr + 8'h01;
      next_s.st = rcsr_pkg::ST_RDAT;
      // freeze the low bits with the high read so both share a sample
      if (s.ptr == rcsr_pkg::ADDR_VHIGH)
      begin
        next_s.vlo = s.vsample[1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.st <= rcsr_pkg::ST_IDLE;
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
      s.gain56 <= rcsr_pkg::GAIN_RST;
      s.gain78 <= rcsr_pkg::GAIN_RST;
      s.latched <= rcsr_pkg::LATCHED_RST;
      s.ocfg <= rcsr_pkg::OCFG_RST;
      s.oc_code <= rcsr_pkg::OC_DEFAULT_CODE;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all from the state register
  // ----------------------------------------------------------------------
  assign sda_out = s.sda_out;  // open drain: always low when enabled
  assign sda_oe = s.sda_oe;
  assign target_voltage_code = s.target_code;
  assign phase5_6_balance_gain = s.gain56;
  assign phase7_8_balance_gain = s.gain78;
  assign phase_balance_gain = s.gain_tenths;
  assign oc_threshold_code = s.oc_code;
  assign oc_ratio = s.oc_tenths;
  assign overcurrent_warning_level = s.warn_tenths;
  assign overcurrent_warning_hysteresis = s.hys_tenths;

endmodule

`default_nettype wire

// >>> testbench/rcsr_monitor.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// port-level checks for the config/status bank
// ----------------------------------------------------------------------
module rcsr_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic sda_out,
  input wire logic [7:0] normal_voltage_code,
  input wire logic latched_code_override_en,
  input wire logic oc_threshold_i2c_en,
  input wire logic [7:0] target_voltage_code,
  input wire logic [7:0] phase5_6_balance_gain,
  input wire logic [7:0] phase7_8_balance_gain,
  input wire logic [3:0][10:0] phase_balance_gain,
  input wire logic [3:0] oc_threshold_code,
  input wire logic [10:0] oc_ratio,
  input wire logic [10:0] overcurrent_warning_level,
  input wire logic [10:0] overcurrent_warning_hysteresis
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  latched_rst_a:
    assert property ($past(rst) && latched_code_override_en |=> target_voltage_code == 8'hab)
    else $error("target not at latched reset code");
  target_norm_a:
    assert property (!$past(rst) && !$past(latched_code_override_en)
      |-> target_voltage_code == $past(normal_voltage_code))
    else $error("target not following normal source");
  gain_odd_a:
    assert property (!$past(rst) |->
      phase_balance_gain[0] == 11'h1f4 + 11'h07d * $past(phase5_6_balance_gain[6:4]))
    else $error("phase five gain decode wrong");
  gain_even_a:
    assert property (!$past(rst) |->
      phase_balance_gain[3] == 11'h1f4 + 11'h07d * $past(phase7_8_balance_gain[2:0]))
    else $error("phase eight gain decode wrong");
  // code and ratio are registered from the same applied code, so compare them in step
  oc_ratio_a:
    assert property (!$past(rst) |-> oc_ratio == 11'h1f4 + 11'h064 * oc_threshold_code)
    else $error("total threshold ratio wrong");
  oc_default_a:
    assert property (!$past(rst) && !$past(oc_threshold_i2c_en) |-> oc_threshold_code == 4'h8)
    else $error("threshold not default while disabled");
  warn_range_a:
    assert property (!$past(rst) |-> overcurrent_warning_level >= 11'h28a
      && overcurrent_warning_level <= 11'h3e8
      && (overcurrent_warning_level - 11'h28a) % 11'h032 == 11'h000)
    else $error("warning level off the decode grid");
  hys_pair_a:
    assert property (!$past(rst) |-> overcurrent_warning_hysteresis == 11'h064
      || overcurrent_warning_hysteresis == 11'h0c8)
    else $error("hysteresis not ten or twenty percent");
  // open drain: the data pin is only ever pulled low, and its drive only changes while clock is low
  drive_low_a:
    assert property (sda_oe |-> sda_out == 1'b0)
    else $error("data pin driven high");
  oe_clk_low_a:
    assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
    else $error("data drive changed while clock high");
endmodule

bind rcsr_top rcsr_monitor rcsr_monitor_inst (
  .mclk(mclk), .rst(rst), .scl_in(scl_in), .sda_oe(sda_oe), .sda_out(sda_out),
  .normal_voltage_code(normal_voltage_code),
  .latched_code_override_en(latched_code_override_en),
  .oc_threshold_i2c_en(oc_threshold_i2c_en), .target_voltage_code(target_voltage_code),
  .phase5_6_balance_gain(phase5_6_balance_gain), .phase7_8_balance_gain(phase7_8_balance_gain),
  .phase_balance_gain(phase_balance_gain), .oc_threshold_code(oc_threshold_code),
  .oc_ratio(oc_ratio), .overcurrent_warning_level(overcurrent_warning_level),
  .overcurrent_warning_hysteresis(overcurrent_warning_hysteresis)
);
`default_nettype wire

// >>> testbench/rcsr_bus_host.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// two-wire bus host model
// ----------------------------------------------------------------------
module rcsr_bus_host #(
  parameter logic [6:0] DEV = 7'h2c
) (
  input wire logic mclk,
  input wire logic sda_line,
  output logic scl,
  output logic sda
);
  logic smp; // line level at end of clock high
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // third of a bit: four cycles keeps every clock level above the minimum
  task automatic half();
    repeat (4) @(posedge mclk);
    #1;
  endtask
  // one clock pulse, data only moves while clock is low
  task automatic pulse();
    half();
    scl = 1'b1;
    half();
    smp = sda_line;
    scl = 1'b0;
    half();
  endtask
  // start, or repeated start from a low clock
  task automatic start();
    sda = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda = 1'b0;
    half();
    scl = 1'b0;
    half();
  endtask
  task automatic stop();
    sda = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda = 1'b1;
    half();
  endtask
  // byte out, msb first; nak is the line level in the ninth bit
  task automatic put(input logic [7:0] b, output logic nak);
    for (int i = 7; i >= 0; i--)
    begin
      sda = b[i];
      pulse();
    end
    sda = 1'b1;
    pulse();
    nak = smp;
  endtask
  // byte in; last gives the closing not-acknowledge
  task automatic get(input logic last, output logic [7:0] b);
    sda = 1'b1;
    for (int i = 7; i >= 0; i--)
    begin
      pulse();
      b[i] = smp;
    end
    sda = last;
    pulse();
    sda = 1'b1;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
                    output logic nak);
    logic n0, n1, n2;
    start();
    put({dev, 1'b0}, n0);
    put(ptr, n1);
    put(d, n2);
    stop();
    nak = n0 | n1 | n2;
  endtask
  // two bytes in one read, so a high/low voltage pair stays one sample
  task automatic rd(input logic [7:0] ptr, output logic [15:0] q);
    logic n;
    start();
    put({DEV, 1'b0}, n);
    put(ptr, n);
    start();
    put({DEV, 1'b1}, n);
    get(1'b0, q[15:8]);
    get(1'b1, q[7:0]);
    stop();
  endtask
endmodule
`default_nettype wire

// >>> testbench/regulator_config_status_regs_test.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// self-checking bench for the config/status bank
// ----------------------------------------------------------------------
module regulator_config_status_regs_test;
  logic mclk, rst, scl_in, host_sda, sda_in, sda_out, sda_oe;
  logic [6:0] i2c_dev_addr;
  logic [7:0] normal_voltage_code, adc_current, phase_overcurrent, target_voltage_code;
  logic latched_code_override_en, oc_threshold_i2c_en, voltage_sense_select;
  logic total_overcurrent_fault, overvoltage_fault, undervoltage_fault;
  logic [9:0] dac_voltage, sensed_voltage;
  logic [7:0] phase5_6_balance_gain, phase7_8_balance_gain;
  logic [3:0][10:0] phase_balance_gain;
  logic [3:0] oc_threshold_code;
  logic [10:0] oc_ratio, overcurrent_warning_level, overcurrent_warning_hysteresis;
  logic [15:0] q; // last two bytes read
  logic nak;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;

  // pulled-up data line: low if either party pulls it
  assign sda_in = host_sda & (sda_oe ? sda_out : 1'b1);

  rcsr_top rcsr_top_inst (.mclk(mclk), .rst(rst), .i2c_dev_addr(i2c_dev_addr),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .normal_voltage_code(normal_voltage_code), .latched_code_override_en(latched_code_override_en),
    .oc_threshold_i2c_en(oc_threshold_i2c_en), .voltage_sense_select(voltage_sense_select),
    .adc_current(adc_current), .dac_voltage(dac_voltage), .sensed_voltage(sensed_voltage),
    .total_overcurrent_fault(total_overcurrent_fault), .phase_overcurrent(phase_overcurrent),
    .overvoltage_fault(overvoltage_fault), .undervoltage_fault(undervoltage_fault),
    .target_voltage_code(target_voltage_code), .phase5_6_balance_gain(phase5_6_balance_gain),
    .phase7_8_balance_gain(phase7_8_balance_gain), .phase_balance_gain(phase_balance_gain),
    .oc_threshold_code(oc_threshold_code), .oc_ratio(oc_ratio),
    .overcurrent_warning_level(overcurrent_warning_level),
    .overcurrent_warning_hysteresis(overcurrent_warning_hysteresis));
  rcsr_bus_host rcsr_bus_host_inst (.mclk(mclk), .sda_line(sda_in), .scl(scl_in),
    .sda(host_sda));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // hang guard, well above the roughly 17k cycles the run needs
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      err_total = err_total + 1;
      conclude();
    end
  end

  task automatic conclude();
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // inputs move 1 ns after the edge, same as the host model
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic rd(input logic [7:0] p);
    rcsr_bus_host_inst.rd(p, q);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    rcsr_bus_host_inst.wr(7'h2c, p, d, nak);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  // reset values, override held through reset; 0x13 and 0x1a are unmapped
  task automatic t_reset();
    chk(target_voltage_code, 8'hab);
    for (int i = 0; i < 4; i++)
      chk(phase_balance_gain[i], 11'h3e8);
    chk(oc_ratio, 11'h514);
    chk(overcurrent_warning_level, 11'h384);
    chk(overcurrent_warning_hysteresis, 11'h064);
    rd(8'h11);
    chk(q, 16'h4444);
    rd(8'h13);
    chk(q, 16'h00ab);
    rd(8'h19);
    chk(q, 16'h8a00);
  endtask
  // extreme and middle codes in all four gain fields
  task automatic t_gain();
    wr(8'h11, 8'h70);
    wr(8'h12, 8'h25);
    chk(phase5_6_balance_gain, 8'h70);
    chk(phase_balance_gain[0], 11'h55f);
    chk(phase_balance_gain[1], 11'h1f4);
    chk(phase_balance_gain[2], 11'h2ee);
    chk(phase_balance_gain[3], 11'h465);
    rd(8'h11);
    chk(q, 16'h7025);
  endtask
  task automatic t_target();
    wr(8'h14, 8'h3c);
    chk(target_voltage_code, 8'h3c);
    latched_code_override_en = 1'b0;
    step(3);
    chk(target_voltage_code, 8'h5c);
  endtask
  // both voltage sources; full-scale current reading
  task automatic t_volt();
    adc_current = 8'hff;
    step(3);
    rd(8'h15);
    chk(q, 16'hffad);
    rd(8'h16);
    chk(q, 16'had03);
    voltage_sense_select = 1'b1;
    step(3);
    rd(8'h16);
    chk(q, 16'h7002);
  endtask
  // phase codes 1 to 8, with phase 8 also faulting to test lowest-wins
  task automatic t_status();
    for (int i = 0; i < 8; i++)
    begin
      total_overcurrent_fault = i[0];
      overvoltage_fault = i[1];
      undervoltage_fault = i[2];
      phase_overcurrent = (8'h01 << i) | 8'h80;
      step(2);
      rd(8'h18);
      chk(q[15:8], {i[0], 1'b1, i[1], i[2], 4'(i + 1)});
    end
    {total_overcurrent_fault, overvoltage_fault, undervoltage_fault} = 3'h0;
    phase_overcurrent = 8'h00;
    wr(8'h18, 8'hff);
    chk(nak, 1'b0);
    wr(8'h15, 8'h00);
    rd(8'h18);
    chk(q[15:12], 4'h0);
    rd(8'h15);
    chk(q[15:8], 8'hff);
  endtask
  // all sixteen threshold codes, then fall back to the default source
  task automatic t_ocfg();
    logic [7:0] v;
    for (int c = 0; c < 16; c++)
    begin
      v = {4'(c), 3'(c + 3), 1'(c)};
      wr(8'h19, v);
      chk(oc_threshold_code, v[7:4]);
      chk(oc_ratio, 11'h1f4 + 11'h064 * v[7:4]);
      chk(overcurrent_warning_level, 11'h28a + 11'h032 * v[3:1]);
      chk(overcurrent_warning_hysteresis, v[0] ? 11'h0c8 : 11'h064);
    end
    oc_threshold_i2c_en = 1'b0;
    step(3);
    chk(oc_threshold_code, 4'h8);
    chk(oc_ratio, 11'h514);
  endtask

  initial
  begin
    rst = 1'b1;
    i2c_dev_addr = 7'h2c;
    normal_voltage_code = 8'h5c;
    latched_code_override_en = 1'b1;
    oc_threshold_i2c_en = 1'b1;
    voltage_sense_select = 1'b0;
    adc_current = 8'h11;
    dac_voltage = 10'h2b7;
    sensed_voltage = 10'h1c2;
    {total_overcurrent_fault, overvoltage_fault, undervoltage_fault} = 3'h0;
    phase_overcurrent = 8'h00;
    step(5);
    rst = 1'b0;
    step(2);
    t_reset();
    t_gain();
    t_target();
    t_volt();
    t_status();
    t_ocfg();
    conclude();
  end
endmodule
`default_nettype wire
